//--- rtl/spc_pkg.sv
// package: register map, field positions and reset values of the serial
// port configuration block
// assumes: 15-bit register address, 8-bit registers
package spc_pkg;

  localparam int          ADDR_W          = 15;
  localparam int          DATA_W          = 8;

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [14:0] ADDR_CFG_A      = 15'h0000;
  localparam logic [14:0] ADDR_CFG_B      = 15'h0001;
  localparam logic [14:0] ADDR_UPDATE     = 15'h000F;
  localparam logic [14:0] ADDR_USER       = 15'h0010;

  // ----------------------------------------------------------------------
  // configuration A fields, upper bit and its mirror
  // ----------------------------------------------------------------------
  localparam int          A_SOFT_RST_HI   = 7;
  localparam int          A_SOFT_RST_LO   = 0;
  localparam int          A_LSB_FIRST_HI  = 6;
  localparam int          A_LSB_FIRST_LO  = 1;
  localparam int          A_ASCEND_HI     = 5;
  localparam int          A_ASCEND_LO     = 2;
  localparam int          A_SDO_EN_HI     = 4;
  localparam int          A_SDO_EN_LO     = 3;

  // ----------------------------------------------------------------------
  // configuration B and update fields
  // ----------------------------------------------------------------------
  localparam int          B_READ_BUF      = 5;
  localparam int          B_LOGIC_RST     = 2;
  localparam int          UPD_STROBE      = 0;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  CFG_A_RST       = 8'h00;
  localparam logic        READ_BUF_RST    = 1'b0;
  localparam logic [7:0]  USER_RST        = 8'h00;

  typedef enum logic [2:0] {
    SPC_IDLE  = 3'b001,
    SPC_INSTR = 3'b010,
    SPC_DATA  = 3'b100
  } spc_state_t;

endpackage

//--- rtl/spc_pin_sync.sv
// file: three-stage synchroniser for one pin, agreed level output
// assumes: pin is asynchronous to core_clk
`timescale 1ns/1ps
module spc_pin_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic pin,
  output logic      level
);

  logic stage1;
  logic stage2;
  logic stage3;

  // level moves only once stages two and three agree
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      stage1 <= RESET_LEVEL;
      stage2 <= RESET_LEVEL;
      stage3 <= RESET_LEVEL;
      level  <= RESET_LEVEL;
    end
    else
    begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3)
        level <= stage3;
    end
  end

endmodule // spc_pin_sync

//--- rtl/spc_serial_port.sv
// file: serial control port slave with its two configuration registers,
// the update strobe and one buffered control register
// assumes: sclk much slower than core_clk (oversampled), mode 0 timing
`timescale 1ns/1ps
module spc_serial_port
  import spc_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                reset,
  input  wire logic                i2c_mode,
  input  wire logic                sclk,
  input  wire logic                csb_n,
  input  wire logic                sdio_in,
  output logic                     sdio_out,
  output logic                     sdio_oe_n,
  output logic                     sdo_out,
  output logic                     sdo_oe_n,
  output logic [spc_pkg::DATA_W-1:0] user_ctrl,
  output logic                     dev_logic_reset
);
  import spc_pkg::*;

  logic              sclk_lvl;
  logic              csb_lvl;
  logic              sdio_lvl;
  logic              i2c_lvl;
  logic              sclk_q;
  logic              csb_q;
  spc_state_t        state;
  logic [2:0]        bit_cnt;
  logic              hi_done;
  logic              rw;
  logic [14:0]       addr;
  logic [7:0]        shreg;
  logic [7:0]        tx;
  logic [7:0]        cfg_a;
  logic              read_buf;
  logic [7:0]        user_buf;
  logic              soft_pend;

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  spc_pin_sync #(.RESET_LEVEL(1'b0)) u_sync_sclk (
    .core_clk (core_clk),
    .reset    (reset),
    .pin      (sclk),
    .level    (sclk_lvl)
  );
  spc_pin_sync #(.RESET_LEVEL(1'b1)) u_sync_csb (
    .core_clk (core_clk),
    .reset    (reset),
    .pin      (csb_n),
    .level    (csb_lvl)
  );
  spc_pin_sync #(.RESET_LEVEL(1'b0)) u_sync_sdio (
    .core_clk (core_clk),
    .reset    (reset),
    .pin      (sdio_in),
    .level    (sdio_lvl)
  );
  spc_pin_sync #(.RESET_LEVEL(1'b0)) u_sync_i2c (
    .core_clk (core_clk),
    .reset    (reset),
    .pin      (i2c_mode),
    .level    (i2c_lvl)
  );

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------
  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++)
      r[i] = v[7-i];
    return r;
  endfunction

  function automatic logic [7:0] rd_reg(input logic [14:0] a,
                                        input logic [7:0]  ca,
                                        input logic        rb,
                                        input logic [7:0]  ub,
                                        input logic [7:0]  ua);
    logic [7:0] d;
    d = 8'h00;
    if (a == ADDR_CFG_A)
      d = ca;
    else if (a == ADDR_CFG_B)
      d[B_READ_BUF] = rb;
    else if (a == ADDR_USER)
      d = rb ? ub : ua;
    return d;
  endfunction

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  // pairwise AND
  wire       lsb_eff    = cfg_a[A_LSB_FIRST_HI] & cfg_a[A_LSB_FIRST_LO] & ~i2c_lvl;
  wire       ascend_eff = cfg_a[A_ASCEND_HI] & cfg_a[A_ASCEND_LO] & ~i2c_lvl;
  wire       sdo_eff    = cfg_a[A_SDO_EN_HI] & cfg_a[A_SDO_EN_LO] & ~i2c_lvl;

  wire       sclk_rise  = sclk_lvl & ~sclk_q;
  wire       sclk_fall  = ~sclk_lvl & sclk_q;
  wire       csb_fall   = ~csb_lvl & csb_q;
  wire [7:0] next_sh    = {shreg[6:0], sdio_lvl};
  wire [7:0] rx_byte    = lsb_eff ? rev8(next_sh) : next_sh;
  wire       byte_done  = sclk_rise && (bit_cnt == 3'd7);
  wire       wr_strobe  = byte_done && (state == SPC_DATA) && !rw && !csb_lvl;
  wire [14:0] step_addr = ascend_eff ? 15'(addr + 15'd1) : 15'(addr - 15'd1);
  wire [14:0] instr_addr = {addr[14:8], rx_byte};
  wire [14:0] load_addr  = (state == SPC_INSTR) ? instr_addr : step_addr;
  wire [7:0]  rd_raw     = rd_reg(load_addr, cfg_a, read_buf, user_buf, user_ctrl);
  wire [7:0]  tx_load    = lsb_eff ? rev8(rd_raw) : rd_raw;
  wire        driving    = (state == SPC_DATA) && rw && !csb_lvl;

  // both bits of the pair required
  wire        soft_hit   = wr_strobe && (addr == ADDR_CFG_A) && !i2c_lvl &&
                           rx_byte[A_SOFT_RST_HI] && rx_byte[A_SOFT_RST_LO];
  wire        logic_hit  = wr_strobe && (addr == ADDR_CFG_B) && rx_byte[B_LOGIC_RST];
  wire        eng_reset  = reset | soft_pend | dev_logic_reset;

  // ----------------------------------------------------------------------
  // frame engine
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      sclk_q <= 1'b0;
      csb_q  <= 1'b1;
    end
    else
    begin
      sclk_q <= sclk_lvl;
      csb_q  <= csb_lvl;
    end
  end

  // a logic reset drops the frame in flight; the host starts a new one
  always_ff @(posedge core_clk)
  begin
    if (eng_reset)
    begin
      state    <= SPC_IDLE;
      bit_cnt  <= 3'd0;
      hi_done  <= 1'b0;
      rw       <= 1'b0;
      addr     <= 15'h0000;
      shreg    <= 8'h00;
      tx       <= 8'h00;
      sdio_out <= 1'b0;
      sdo_out  <= 1'b0;
    end
    else
    begin
      case (state)
        SPC_IDLE:
        begin
          bit_cnt <= 3'd0;
          hi_done <= 1'b0;
          if (csb_fall)
            state <= SPC_INSTR;
        end
        SPC_INSTR:
        begin
          if (csb_lvl)
            state <= SPC_IDLE;
          else if (sclk_rise)
          begin
            shreg   <= next_sh;
            bit_cnt <= 3'(bit_cnt + 3'd1);
            if (byte_done && !hi_done)
            begin
              rw         <= rx_byte[7];
              addr[14:8] <= rx_byte[6:0];
              hi_done    <= 1'b1;
            end
            else if (byte_done)
            begin
              addr  <= instr_addr;
              tx    <= tx_load;
              state <= SPC_DATA;
            end
          end
        end
        SPC_DATA:
        begin
          if (csb_lvl)
            state <= SPC_IDLE;
          else if (sclk_rise)
          begin
            shreg   <= next_sh;
            bit_cnt <= 3'(bit_cnt + 3'd1);
            if (byte_done)
            begin
              addr <= step_addr;
              tx   <= tx_load;
            end
          end
          else if (sclk_fall && rw)
          begin
            sdio_out <= tx[7];
            sdo_out  <= tx[7];
            tx       <= {tx[6:0], 1'b0};
          end
        end
        default:
          state <= SPC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      sdio_oe_n <= 1'b1;
      sdo_oe_n  <= 1'b1;
    end
    else
    begin
      // read data on separate pin in 4-wire mode
      sdio_oe_n <= ~(driving & ~sdo_eff);
      sdo_oe_n  <= ~(driving & sdo_eff);
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  // soft reset returns every register to default
  always_ff @(posedge core_clk)
  begin
    if (reset | soft_pend)
    begin
      cfg_a     <= CFG_A_RST;
      read_buf  <= READ_BUF_RST;
      user_buf  <= USER_RST;
      user_ctrl <= USER_RST;
    end
    else if (wr_strobe)
    begin
      if (addr == ADDR_CFG_A)
        cfg_a <= rx_byte;
      if (addr == ADDR_CFG_B)
        read_buf <= rx_byte[B_READ_BUF];
      if (addr == ADDR_USER)
        user_buf <= rx_byte;
      // strobe is never stored, so it reads back zero
      if (addr == ADDR_UPDATE && rx_byte[UPD_STROBE])
        user_ctrl <= user_buf;
    end
  end

  // outside i2c_mode the soft reset bits are stored in cfg_a for one cycle: the reset that follows clears them
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      soft_pend       <= 1'b0;
      dev_logic_reset <= 1'b0;
    end
    else
    begin
      soft_pend       <= soft_hit;
      dev_logic_reset <= soft_hit | logic_hit;
    end
  end

endmodule // spc_serial_port

//--- tb/spc_monitor.sv
// checker: port-level properties of the serial configuration port
// assumes: bound to every spc_serial_port instance, one clock domain
`timescale 1ns/1ps
module spc_monitor (
  input wire logic       core_clk,
  input wire logic       reset,
  input wire logic       csb_n,
  input wire logic       sdio_out,
  input wire logic       sdio_oe_n,
  input wire logic       sdo_out,
  input wire logic       sdo_oe_n,
  input wire logic [7:0] user_ctrl,
  input wire logic       dev_logic_reset
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  chk_one_data_pin: assert property (sdio_oe_n || sdo_oe_n)
    else $error("both data pins enabled");
  chk_oe_in_frame: assert property ($fell(sdio_oe_n) || $fell(sdo_oe_n) |-> !csb_n)
    else $error("pin enabled outside frame");
  chk_oe_idle_high: assert property (csb_n [*8] |-> sdio_oe_n && sdo_oe_n)
    else $error("pin still enabled after frame");
  chk_pins_agree: assert property (sdio_out == sdo_out)
    else $error("data pins disagree");
  chk_rst_pulse: assert property (dev_logic_reset |=> !dev_logic_reset)
    else $error("logic reset longer than one cycle");
  chk_rst_in_frame: assert property (dev_logic_reset |-> !csb_n)
    else $error("logic reset outside a write");
  chk_ctrl_in_frame: assert property ($changed(user_ctrl) |-> !csb_n)
    else $error("user_ctrl moved outside a frame");
  chk_rst_clears: assert property ($past(dev_logic_reset) && $changed(user_ctrl)
    |-> user_ctrl == 8'h00)
    else $error("reset loaded a nonzero value");
  chk_reset_values: assert property ($fell(reset) |-> user_ctrl == 8'h00 && sdio_oe_n
    && sdo_oe_n && !dev_logic_reset)
    else $error("bad values after reset");
  cover property ($fell(sdo_oe_n));
  cover property ($fell(sdio_oe_n));
  cover property (dev_logic_reset);
  cover property ($changed(user_ctrl));
endmodule // spc_monitor
bind spc_serial_port spc_monitor u_mon (.core_clk, .reset, .csb_n, .sdio_out, .sdio_oe_n,
  .sdo_out, .sdo_oe_n, .user_ctrl, .dev_logic_reset);

//--- tb/spc_host_model.sv
// partner: serial port host issuing register frames, mode 0 timing
// assumes: sclk half period of 8 core_clk cycles, driven at rising edges
`timescale 1ns/1ps
module spc_host_model (
  input  wire logic core_clk,
  output logic      sclk,
  output logic      csb_n,
  output logic      sdio_in,
  input  wire logic sdio_out,
  input  wire logic sdio_oe_n,
  input  wire logic sdo_out,
  input  wire logic sdo_oe_n
);
  logic [7:0] dat [4];
  logic       oe3;
  logic       oe4;
  initial
  begin
    sclk = 1'b0;
    csb_n = 1'b1;
    sdio_in = 1'b0;
  end
  // ----------------------------------------------------------------------
  // one frame: two instruction bytes, then n data bytes
  // ----------------------------------------------------------------------
  task automatic frame(input bit rd, input logic [14:0] a, input int n, input logic lsb);
    logic [7:0] b;
    oe3 = 1'b0;
    oe4 = 1'b0;
    @(posedge core_clk) csb_n <= 1'b0;
    for (int k = 0; k < n + 2; k++)
    begin
      b = (k == 0) ? {rd, a[14:8]} : (k == 1) ? a[7:0] : dat[k-2];
      for (int i = 0; i < 8; i++)
      begin
        if (k < 2 || !rd)
          sdio_in <= b[lsb ? i : 7-i];
        else
          sdio_in <= ~sdio_in;
        repeat (8) @(posedge core_clk);
        sclk <= 1'b1;
        if (k > 1 && rd)
        begin
          // a pin left undriven reads as the inverse of its stale bit
          dat[k-2][lsb ? i : 7-i] = !sdo_oe_n ? sdo_out : !sdio_oe_n ? sdio_out : ~sdio_out;
          oe3 |= !sdio_oe_n;
          oe4 |= !sdo_oe_n;
        end
        repeat (8) @(posedge core_clk);
        sclk <= 1'b0;
      end
    end
    // released line toggles so a stale bit is never mistaken for data
    sdio_in <= ~sdio_in;
    repeat (12) @(posedge core_clk);
    csb_n <= 1'b1;
    repeat (12) @(posedge core_clk);
  endtask
endmodule // spc_host_model

//--- tb/tb.sv
// testbench: host model frames against a behavioural register model
// assumes: checker and host model compiled beforehand
`timescale 1ns/1ps
module tb;
  import spc_pkg::*;
  logic       core_clk = 1'b0;
  logic       reset    = 1'b1;
  logic       i2c_mode = 1'b0;
  wire        sclk, csb_n, sdio_in, sdio_out, sdio_oe_n, sdo_out, sdo_oe_n;
  wire  [7:0] user_ctrl;
  wire        dev_logic_reset;
  logic [7:0] ra = 8'h00, rb = 8'h00, ub = 8'h00, ua = 8'h00;
  int         err_total, checked, pulses, n_pulse;
  int         lone[8] = '{8'h40, 8'h02, 8'h20, 8'h04, 8'h10, 8'h08, 8'h80, 8'h01};
  int         pair[3] = '{8'h42, 8'h24, 8'h18};
  spc_serial_port u_dut (.core_clk, .reset, .i2c_mode, .sclk, .csb_n, .sdio_in, .sdio_out,
    .sdio_oe_n, .sdo_out, .sdo_oe_n, .user_ctrl, .dev_logic_reset);
  spc_host_model u_host (.core_clk, .sclk, .csb_n, .sdio_in, .sdio_out, .sdio_oe_n,
    .sdo_out, .sdo_oe_n);
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk)
    if (dev_logic_reset === 1'b1)
      pulses++;
  // ----------------------------------------------------------------------
  // model and helpers
  // ----------------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string w);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", w, exp, seen);
    end
  endtask
  function automatic logic [7:0] peek(input int a);
    case (a)
      ADDR_CFG_A: return ra;
      ADDR_CFG_B: return rb;
      ADDR_USER:  return rb[5] ? ub : ua;
      default:    return 8'h00;
    endcase
  endfunction
  task automatic apply(input int a, input logic [7:0] v);
    if (a == ADDR_CFG_A) ra = v;
    if (a == ADDR_CFG_B) rb = v & 8'h20;
    if (a == ADDR_USER) ub = v;
    if (a == ADDR_UPDATE && v[0]) ua = ub;
    if ((a == ADDR_CFG_A && v[7] && v[0]) || (a == ADDR_CFG_B && v[2])) n_pulse++;
    if (a == ADDR_CFG_A && v[7] && v[0]) {ra, rb, ub, ua} = '0;
  endtask
  task automatic xfer(input bit rd, input logic [14:0] a, input int n);
    int   ad;
    int   st;
    logic four;
    ad = a;
    st = (ra[5] & ra[2] & !i2c_mode) ? 1 : -1;
    four = ra[4] & ra[3] & !i2c_mode;
    u_host.frame(rd, a, n, ra[6] & ra[1] & !i2c_mode);
    for (int k = 0; k < n; k++)
    begin
      if (rd)
        chk(u_host.dat[k], peek(ad), "read");
      else
        apply(ad, u_host.dat[k]);
      ad = (ad + st) & 32'h7FFF;
    end
    if (rd)
      chk({6'h00, u_host.oe3, u_host.oe4}, four ? 8'h01 : 8'h02, "pins");
    chk(user_ctrl, ua, "user_ctrl");
    chk(pulses[7:0], n_pulse[7:0], "pulses");
  endtask
  task automatic wr1(input logic [14:0] a, input logic [7:0] v);
    u_host.dat[0] = v;
    xfer(1'b0, a, 1);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (90000) @(posedge core_clk);
    err_total++;
    close_out();
  end
  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial
  begin
    void'($urandom(64));
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    repeat (8) @(posedge core_clk);
    xfer(1'b1, ADDR_CFG_A, 1);
    xfer(1'b1, ADDR_CFG_B, 1);
    wr1(ADDR_USER, 8'($urandom_range(255)));
    wr1(15'h0007, 8'h5A);
    xfer(1'b1, 15'h0007, 1);
    wr1(ADDR_CFG_B, 8'($urandom_range(255)));
    xfer(1'b1, ADDR_USER, 1);
    wr1(ADDR_UPDATE, 8'h01);
    xfer(1'b1, ADDR_UPDATE, 1);
    wr1(ADDR_CFG_B, 8'h24);
    xfer(1'b1, ADDR_USER, 1);
    $display("test buffered registers done");
    // lone bits of a pair are stored but must not act
    foreach (lone[i])
    begin
      wr1(ADDR_CFG_A, lone[i][7:0]);
      xfer(1'b1, ADDR_CFG_A, 1);
    end
    foreach (pair[i])
    begin
      wr1(ADDR_CFG_A, pair[i][7:0]);
      xfer(1'b1, ADDR_CFG_B, 2);
      u_host.dat[0] = 8'h00;
      u_host.dat[1] = 8'($urandom_range(255));
      xfer(1'b0, ADDR_UPDATE, 2);
      xfer(1'b1, ADDR_USER, 1);
      wr1(ADDR_CFG_A, 8'h00);
    end
    $display("test mirrored pairs done");
    wr1(ADDR_CFG_A, 8'h42);
    i2c_mode <= 1'b1;
    repeat (8) @(posedge core_clk);
    xfer(1'b1, ADDR_CFG_A, 1);
    i2c_mode <= 1'b0;
    repeat (8) @(posedge core_clk);
    wr1(ADDR_CFG_A, 8'h00);
    $display("test second bus mode done");
    wr1(ADDR_USER, 8'($urandom_range(255)));
    wr1(ADDR_UPDATE, 8'h01);
    wr1(ADDR_CFG_A, 8'h81);
    xfer(1'b1, ADDR_CFG_A, 1);
    xfer(1'b1, ADDR_CFG_B, 1);
    xfer(1'b1, ADDR_USER, 1);
    $display("test full reset done");
    close_out();
  end
endmodule // tb
